// ### pkg/tcr_pkg.sv
// Purpose: Shared constants and types for the timer count readout block.
// Assumes: Eight-bit host bus, three sixteen-bit counting elements.
// Notes:   Every offset and field position lives here, with the mode word reset value.
package tcr_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_CNT = 3;
    localparam int CNT_W   = 16;
    localparam int MODE_W  = 6;

    // ----------------------------------------------------------------
    // Port addresses on port_index_hi, port_index_lo
    // ----------------------------------------------------------------
    localparam logic [1:0] PORT_CNT0 = 2'h0;
    localparam logic [1:0] PORT_CNT1 = 2'h1;
    localparam logic [1:0] PORT_CNT2 = 2'h2;
    localparam logic [1:0] PORT_CTRL = 2'h3;

    // ----------------------------------------------------------------
    // Control byte fields
    // ----------------------------------------------------------------
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;
    localparam int ACC_HI_BIT = 5;
    localparam int ACC_LO_BIT = 4;

    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH    = 2'h0;
    localparam logic [1:0] ACC_LSB      = 2'h1;
    localparam logic [1:0] ACC_MSB      = 2'h2;
    localparam logic [1:0] ACC_BOTH     = 2'h3;

    // Mode word holds control byte bits 5..0; format in bits 5..4.
    localparam int FMT_HI_BIT = 5;
    localparam int FMT_LO_BIT = 4;
    localparam logic [MODE_W-1:0] MODE_RESET = 6'h30;

    // ----------------------------------------------------------------
    // Byte pointer
    // ----------------------------------------------------------------
    typedef enum logic {
        PTR_LOW  = 1'b0,
        PTR_HIGH = 1'b1
    } tcr_ptr_t;

endpackage : tcr_pkg

// ### pkg/tcr_bus_if.sv
// Purpose: Carries decoded host bus events from the front end to the core.
// Assumes: One clock domain.
// Notes:   Pulses are one clock wide.
`timescale 1ns/1ps
interface tcr_bus_if;
    logic       wr_pulse;
    logic [1:0] wr_port;
    logic [7:0] wr_data;
    logic       rd_pulse;
    logic [1:0] rd_port;

    modport front (
        output wr_pulse,
        output wr_port,
        output wr_data,
        output rd_pulse,
        output rd_port
    );

    modport core (
        input wr_pulse,
        input wr_port,
        input wr_data,
        input rd_pulse,
        input rd_port
    );
endinterface : tcr_bus_if

// ### design/tcr_bus_front.sv
// Purpose: Turns host strobes into one-cycle write and read-done pulses.
// Assumes: Strobes are synchronous to i_clock.
// Notes:   An access is taken when its strobe is released.
`timescale 1ns/1ps
module tcr_bus_front (
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic       i_select_n,
    input  wire logic       i_read_n,
    input  wire logic       i_write_n,
    input  wire logic [1:0] i_port,
    input  wire logic [7:0] i_data,
    tcr_bus_if.front        bus
);
    logic wr_act;
    logic rd_act;
    logic wr_prev;
    logic rd_prev;

    // Both strobes low together is no operation.
    assign wr_act = !i_select_n && !i_write_n && i_read_n;
    assign rd_act = !i_select_n && !i_read_n && i_write_n;

    // ----------------------------------------------------------------
    // Strobe history
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
        end else begin
            wr_prev <= wr_act;
            rd_prev <= rd_act;
        end
    end

    // Address and data are kept from the last active strobe cycle.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            bus.wr_port <= 2'h0;
            bus.wr_data <= 8'h00;
            bus.rd_port <= 2'h0;
        end else begin
            if (wr_act) begin
                bus.wr_port <= i_port;
                bus.wr_data <= i_data;
            end
            if (rd_act) begin
                bus.rd_port <= i_port;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            bus.wr_pulse <= 1'b0;
            bus.rd_pulse <= 1'b0;
        end else begin
            bus.wr_pulse <= wr_prev && !wr_act;
            bus.rd_pulse <= rd_prev && !rd_act;
        end
    end
endmodule : tcr_bus_front

// ### design/tcr_ctl_decode.sv
// Purpose: Classifies a byte written to the control port.
// Assumes: Only meaningful together with a control port write.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module tcr_ctl_decode (
    input  wire logic [7:0] i_byte,
    output logic            o_is_latch,
    output logic            o_is_mode,
    output logic [2:0]      o_target
);
    logic [1:0] sel;
    logic [1:0] acc;

    assign sel = {i_byte[tcr_pkg::SEL_HI_BIT], i_byte[tcr_pkg::SEL_LO_BIT]};
    assign acc = {i_byte[tcr_pkg::ACC_HI_BIT], i_byte[tcr_pkg::ACC_LO_BIT]};

    // Select code three is the read-back command, not handled here.
    always_comb begin
        o_target = 3'h0;
        if (sel != tcr_pkg::SEL_READBACK) begin
            o_target[sel] = 1'b1;
        end
    end

    // Low four bits play no part in a latch command.
    assign o_is_latch = (acc == tcr_pkg::ACC_LATCH);
    assign o_is_mode  = (acc != tcr_pkg::ACC_LATCH);
endmodule : tcr_ctl_decode

// ### design/tcr_readout.sv
// Purpose: Count readout path with per-counter output latches.
// Assumes: Counting elements live outside and present their live values.
// Notes:   Count bytes written by the host are passed on as load strobes.
//
// Behaviour
// - Latch command is written to control port.
// - Top two bits choose counter; three is read-back.
// - Bits five and four zero mean latch command.
// - Latch captures counting element value at command.
// - Frozen value holds until read or reprogrammed.
// - After full read latch follows counter again.
// - Latching and reading never disturb counting.
// - Each counter has its own latch state.
// - Latch command leaves mode and format untouched.
// - Second latch before reading is ignored.
// - Reads follow format; two-byte is low then high.
// - Other accesses may come between byte reads.
// - Read and write pointers advance independently.
// - Counters track programming progress independently.
`timescale 1ns/1ps
module tcr_readout (
    input  wire logic                       i_clock,
    input  wire logic                       i_resetn,
    input  wire logic                       i_select_n,
    input  wire logic                       i_read_n,
    input  wire logic                       i_write_n,
    input  wire logic                       i_port_index_hi,
    input  wire logic                       i_port_index_lo,
    input  wire logic [7:0]                 i_data,
    input  wire logic [2:0][15:0]           i_count_value,
    output logic      [7:0]                 o_data,
    output logic                            o_data_oe,
    output logic      [2:0]                 o_load_strobe,
    output logic      [7:0]                 o_load_byte,
    output logic                            o_load_high,
    output logic      [2:0]                 o_mode_load,
    output wire logic [2:0][5:0]            o_mode_word,
    output wire logic [2:0]                 o_latched
);
    // ----------------------------------------------------------------
    // Byte selection shared by the read and write paths
    // ----------------------------------------------------------------
    // Single-byte formats always use their own byte; the two-byte
    // format takes whichever byte the pointer names.
    function automatic logic use_high(
        input logic [1:0]       fmt,
        input tcr_pkg::tcr_ptr_t ptr
    );
        logic r;
        r = 1'b0;
        case (fmt)
            tcr_pkg::ACC_MSB:  r = 1'b1;
            tcr_pkg::ACC_BOTH: r = (ptr == tcr_pkg::PTR_HIGH);
            default:           r = 1'b0;
        endcase
        return r;
    endfunction : use_high

    // ----------------------------------------------------------------
    // Front end and control decode
    // ----------------------------------------------------------------
    tcr_bus_if bus ();

    logic [1:0] port;
    logic       ctl_is_latch;
    logic       ctl_is_mode;
    logic [2:0] ctl_target;
    logic       ctl_write;

    assign port = {i_port_index_hi, i_port_index_lo};

    tcr_bus_front u_front (
        .i_clock    (i_clock),
        .i_resetn   (i_resetn),
        .i_select_n (i_select_n),
        .i_read_n   (i_read_n),
        .i_write_n  (i_write_n),
        .i_port     (port),
        .i_data     (i_data),
        .bus        (bus.front)
    );

    tcr_ctl_decode u_decode (
        .i_byte     (bus.wr_data),
        .o_is_latch (ctl_is_latch),
        .o_is_mode  (ctl_is_mode),
        .o_target   (ctl_target)
    );

    assign ctl_write = bus.wr_pulse && (bus.wr_port == tcr_pkg::PORT_CTRL);

    // ----------------------------------------------------------------
    // Per-counter state
    // ----------------------------------------------------------------
    wire logic [2:0][15:0] ol_all;
    wire logic [2:0][1:0]  fmt_all;
    wire logic [2:0]       rd_ptr_all;
    wire logic [2:0]       wr_ptr_all;

    genvar g;
    generate
        for (g = 0; g < tcr_pkg::NUM_CNT; g++) begin : g_cnt
            logic [tcr_pkg::MODE_W-1:0] mode_word;
            logic [tcr_pkg::CNT_W-1:0]  output_latch;
            logic                       latched;
            tcr_pkg::tcr_ptr_t          rd_ptr;
            tcr_pkg::tcr_ptr_t          wr_ptr;
            tcr_pkg::tcr_ptr_t          next_rd_ptr;
            tcr_pkg::tcr_ptr_t          next_wr_ptr;
            logic [1:0]                 fmt;
            logic                       mode_load;
            logic                       latch_cmd;
            logic                       rd_here;
            logic                       wr_here;
            logic                       last_byte;

            assign fmt = {mode_word[tcr_pkg::FMT_HI_BIT],
                          mode_word[tcr_pkg::FMT_LO_BIT]};
            assign mode_load = ctl_write && ctl_target[g] && ctl_is_mode;
            assign latch_cmd = ctl_write && ctl_target[g] && ctl_is_latch;
            assign rd_here = bus.rd_pulse && (bus.rd_port == 2'(g));
            assign wr_here = bus.wr_pulse && (bus.wr_port == 2'(g));
            assign last_byte = (fmt != tcr_pkg::ACC_BOTH) ||
                               (rd_ptr == tcr_pkg::PTR_HIGH);

            // Only a mode write touches the mode word.
            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    mode_word <= tcr_pkg::MODE_RESET;
                end else if (mode_load) begin
                    mode_word <= bus.wr_data[tcr_pkg::MODE_W-1:0];
                end
            end

            // A later latch command while frozen finds latched set
            // and leaves the first captured value in place.
            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    output_latch <= 16'h0000;
                end else if (!latched) begin
                    output_latch <= i_count_value[g];
                end
            end

            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    latched <= 1'b0;
                end else if (mode_load) begin
                    latched <= 1'b0;
                end else if (latch_cmd) begin
                    latched <= 1'b1;
                end else if (rd_here && last_byte) begin
                    latched <= 1'b0;
                end
            end

            always_comb begin
                next_rd_ptr = rd_ptr;
                if (mode_load) begin
                    next_rd_ptr = tcr_pkg::PTR_LOW;
                end else if (rd_here && fmt == tcr_pkg::ACC_BOTH) begin
                    case (rd_ptr)
                        tcr_pkg::PTR_LOW:  next_rd_ptr = tcr_pkg::PTR_HIGH;
                        tcr_pkg::PTR_HIGH: next_rd_ptr = tcr_pkg::PTR_LOW;
                        default:           next_rd_ptr = tcr_pkg::PTR_LOW;
                    endcase
                end
            end

            // The write pointer has its own state so a write between
            // the two reads does not move the read side.
            always_comb begin
                next_wr_ptr = wr_ptr;
                if (mode_load) begin
                    next_wr_ptr = tcr_pkg::PTR_LOW;
                end else if (wr_here && fmt == tcr_pkg::ACC_BOTH) begin
                    case (wr_ptr)
                        tcr_pkg::PTR_LOW:  next_wr_ptr = tcr_pkg::PTR_HIGH;
                        tcr_pkg::PTR_HIGH: next_wr_ptr = tcr_pkg::PTR_LOW;
                        default:           next_wr_ptr = tcr_pkg::PTR_LOW;
                    endcase
                end
            end

            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    rd_ptr <= tcr_pkg::PTR_LOW;
                    wr_ptr <= tcr_pkg::PTR_LOW;
                end else begin
                    rd_ptr <= next_rd_ptr;
                    wr_ptr <= next_wr_ptr;
                end
            end

            assign ol_all[g]      = output_latch;
            assign fmt_all[g]     = fmt;
            assign rd_ptr_all[g]  = rd_ptr;
            assign wr_ptr_all[g]  = wr_ptr;
            assign o_mode_word[g] = mode_word;
            assign o_latched[g]   = latched;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Count byte hand-off to the counting elements
    // ----------------------------------------------------------------
    // The counting elements are never stalled or written by the
    // readout path; they only receive bytes the host writes.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_load_strobe <= 3'h0;
            o_load_byte   <= 8'h00;
            o_load_high   <= 1'b0;
            o_mode_load   <= 3'h0;
        end else begin
            o_load_strobe <= 3'h0;
            o_mode_load   <= 3'h0;
            o_load_byte   <= bus.wr_data;
            if (ctl_write && ctl_is_mode) begin
                o_mode_load <= ctl_target;
            end
            if (bus.wr_pulse && bus.wr_port != tcr_pkg::PORT_CTRL) begin
                o_load_strobe[bus.wr_port] <= 1'b1;
                o_load_high <= use_high(fmt_all[bus.wr_port],
                                        tcr_pkg::tcr_ptr_t'(
                                            wr_ptr_all[bus.wr_port]));
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Data follows the live address one clock late, so the host should
    // sample it no earlier than the second cycle of its read strobe.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data <= 8'h00;
        end else if (port == tcr_pkg::PORT_CTRL) begin
            o_data <= 8'h00;
        end else if (use_high(fmt_all[port],
                              tcr_pkg::tcr_ptr_t'(rd_ptr_all[port]))) begin
            o_data <= ol_all[port][15:8];
        end else begin
            o_data <= ol_all[port][7:0];
        end
    end

    // The control port is write only and never drives the bus.
    assign o_data_oe = !i_select_n && !i_read_n && i_write_n &&
                       (port != tcr_pkg::PORT_CTRL);
endmodule : tcr_readout

// ### sim/tcr_count_model.sv
// Purpose: Counting element model feeding live values to the readout.
// Assumes: One clock; each counter steps down while its gate is high.
// Notes:   Start values are plain defaults of no significance.
`timescale 1ns/1ps
module tcr_count_model #(
    parameter logic [2:0][15:0] START = {16'h9abc, 16'h5678, 16'h1234}
) (
    input  wire logic            i_clock,
    input  wire logic            i_resetn,
    input  wire logic [2:0]      i_gate,
    output wire logic [2:0][15:0] o_count_value
);
    logic [2:0][15:0] cnt;

    assign o_count_value = cnt;

    // A stopped gate holds the value still for a plain read.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= START;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (i_gate[i]) begin
                    cnt[i] <= cnt[i] - 16'h0001;
                end
            end
        end
    end
endmodule : tcr_count_model

// ### sim/tcr_readout_assertions.sv
// Purpose: Port checks for the count readout block.
// Assumes: The host leaves idle cycles between accesses.
// Notes:   Write effects are seen two samples after strobe release.
`timescale 1ns/1ps
module tcr_readout_checker (
    input wire logic            i_clock,
    input wire logic            i_resetn,
    input wire logic            i_select_n,
    input wire logic            i_read_n,
    input wire logic            i_write_n,
    input wire logic            i_port_index_hi,
    input wire logic            i_port_index_lo,
    input wire logic [7:0]      i_data,
    input wire logic [7:0]      o_data,
    input wire logic            o_data_oe,
    input wire logic [2:0]      o_load_strobe,
    input wire logic [7:0]      o_load_byte,
    input wire logic [2:0]      o_mode_load,
    input wire logic [2:0][5:0] o_mode_word,
    input wire logic [2:0]      o_latched
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [1:0] port;
    logic       wr_act;
    logic       wr_was;
    logic       fell;
    logic       rd3;
    logic       is_lat;
    logic       is_mode;
    logic [1:0] lp;
    logic [7:0] ld;

    assign port = {i_port_index_hi, i_port_index_lo};
    assign wr_act = !i_select_n && !i_write_n && i_read_n;
    assign fell = wr_was && !wr_act;
    assign rd3 = !i_select_n && !i_read_n && i_write_n && port == 2'h3;
    assign is_lat = fell && lp == 2'h3 && ld[5:4] == 2'h0
                    && ld[7:6] != 2'h3;
    assign is_mode = fell && lp == 2'h3 && ld[5:4] != 2'h0
                     && ld[7:6] != 2'h3;

    // The last active cycle of a write carries its port and byte.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_was <= 1'b0;
            lp     <= 2'h0;
            ld     <= 8'h00;
        end else begin
            wr_was <= wr_act;
            if (wr_act) begin
                lp <= port;
                ld <= i_data;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_latch_sets: assert property (is_lat |-> ##2 o_latched[ld[7:6]])
        else $error("latch command did not freeze the counter");
    a_latch_cause: assert property (!$past(is_lat, 2)
        |-> (o_latched & ~$past(o_latched)) == 3'h0)
        else $error("output latch froze without a latch command");
    a_latch_mode: assert property (is_lat
        |-> ##2 ($stable(o_mode_word) && o_mode_load == 3'h0))
        else $error("latch command changed a mode");
    a_readback_ign: assert property (fell && lp == 2'h3
        && ld[7:6] == 2'h3 |-> ##2 $stable(o_latched))
        else $error("read-back select was not ignored");
    a_mode_clear: assert property (is_mode |-> ##2
        (o_mode_word[ld[7:6]] == ld[5:0] && o_mode_load[ld[7:6]]
        && !o_latched[ld[7:6]]))
        else $error("mode write did not load mode and clear latch");
    a_count_load: assert property (fell && lp != 2'h3
        |-> ##2 (o_load_strobe[lp] && o_load_byte == ld))
        else $error("count byte write not passed on");
    a_pulse_one: assert property (o_load_strobe != 3'h0
        |=> o_load_strobe == 3'h0)
        else $error("load strobe wider than one cycle");
    a_oe_decode: assert property (o_data_oe == (!i_select_n
        && !i_read_n && i_write_n && port != 2'h3))
        else $error("data enable does not match the access decode");
    a_ctrl_quiet: assert property (rd3 ##1 rd3 |-> o_data == 8'h00)
        else $error("control port read returned data");

    c_latch: cover property (is_lat);
    c_mode: cover property (is_mode);
    c_two_held: cover property (o_latched == 3'h5);
endmodule : tcr_readout_checker

bind tcr_readout tcr_readout_checker chk_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_select_n(i_select_n),
    .i_read_n(i_read_n), .i_write_n(i_write_n),
    .i_port_index_hi(i_port_index_hi), .i_port_index_lo(i_port_index_lo),
    .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_load_strobe(o_load_strobe), .o_load_byte(o_load_byte),
    .o_mode_load(o_mode_load), .o_mode_word(o_mode_word),
    .o_latched(o_latched)
);

// ### sim/tcr_readout_test.sv
// Purpose: Self-checking bench for the count readout block.
// Assumes: Host bus driven on rising edges, gates stop the counters.
// Notes:   Expected counts come from the counting element model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tcr_readout_test;
    logic             i_clock = 1'b0;
    logic             i_resetn = 1'b0;
    logic             i_select_n = 1'b1;
    logic             i_read_n = 1'b1;
    logic             i_write_n = 1'b1;
    logic [1:0]       port = 2'h0;
    logic [7:0]       i_data = 8'h00;
    logic [2:0]       gate = 3'h0;
    wire logic [2:0][15:0] cv;
    logic [7:0]       o_data;
    logic             o_data_oe;
    logic [2:0]       o_load_strobe;
    logic [7:0]       o_load_byte;
    logic             o_load_high;
    logic [2:0]       o_mode_load;
    wire logic [2:0][5:0] o_mode_word;
    wire logic [2:0]  o_latched;
    logic [2:0]       ld_str;
    logic             ld_hi;
    logic [7:0]       b;
    logic [15:0]      v;
    logic [15:0]      w;
    int               err_total = 0;
    int               comparisons = 0;

    tcr_count_model model_u (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_gate(gate), .o_count_value(cv));
    tcr_readout dut_u (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_select_n(i_select_n), .i_read_n(i_read_n),
        .i_write_n(i_write_n), .i_port_index_hi(port[1]),
        .i_port_index_lo(port[0]), .i_data(i_data), .i_count_value(cv),
        .o_data(o_data), .o_data_oe(o_data_oe),
        .o_load_strobe(o_load_strobe), .o_load_byte(o_load_byte),
        .o_load_high(o_load_high), .o_mode_load(o_mode_load),
        .o_mode_word(o_mode_word), .o_latched(o_latched));

    initial begin
        forever #50 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        @(posedge i_clock);
        i_select_n <= 1'b0;
        i_write_n <= 1'b0;
        port <= p;
        i_data <= d;
        @(posedge i_clock);
        i_select_n <= 1'b1;
        i_write_n <= 1'b1;
        ld_str = 3'h0;
        // Watching five edges also keeps idle time between accesses.
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clock);
            #1;
            if (o_load_strobe !== 3'h0) begin
                ld_str = o_load_strobe;
                ld_hi = o_load_high;
            end
        end
    endtask : wr

    task automatic rd(input logic [1:0] p, output logic [7:0] q);
        @(posedge i_clock);
        i_select_n <= 1'b0;
        i_read_n <= 1'b0;
        port <= p;
        @(posedge i_clock);
        #1 q = o_data;
        @(posedge i_clock);
        i_select_n <= 1'b1;
        i_read_n <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask : rd

    task automatic rd2(input logic [1:0] p, output logic [15:0] q);
        rd(p, q[7:0]);
        rd(p, q[15:8]);
    endtask : rd2

    task automatic run(input logic [2:0] g, input int n);
        @(posedge i_clock) gate <= g;
        repeat (n) @(posedge i_clock);
        gate <= 3'h0;
        repeat (2) @(posedge i_clock);
    endtask : run

    task automatic test_done;
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        test_done();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clock);
        i_resetn <= 1'b1;
        for (int i = 0; i < 3; i++) `CHK("mode", o_mode_word[i], 6'h30)
        rd2(2'h0, v);
        `CHK("plain", v, cv[0])
        v = cv[1];
        wr(2'h3, 8'h40);
        `CHK("latched", o_latched, 3'h2)
        @(posedge i_clock) gate <= 3'h7;
        repeat (20) @(posedge i_clock);
        wr(2'h3, 8'h40);
        rd(2'h1, w[7:0]);
        wr(2'h2, 8'h5a);
        `CHK("load", {ld_str, ld_hi}, 4'h8)
        rd(2'h1, w[15:8]);
        `CHK("frozen", w, v)
        `CHK("released", o_latched, 3'h0)
        run(3'h0, 1);
        rd2(2'h1, w);
        `CHK("follow", w, cv[1])
        rd(2'h0, v[7:0]);
        wr(2'h0, 8'h11);
        `CHK("ld lo", {ld_str, ld_hi}, 4'h2)
        rd(2'h0, v[15:8]);
        wr(2'h0, 8'h22);
        `CHK("ld hi", {ld_str, ld_hi}, 4'h3)
        `CHK("mixed", v, cv[0])
        v = cv[0];
        w = cv[2];
        wr(2'h3, 8'h00);
        wr(2'h3, 8'h8f);
        `CHK("two", o_latched, 3'h5)
        `CHK("mode2", o_mode_word[2], 6'h30)
        run(3'h7, 10);
        rd2(2'h0, v);
        `CHK("c0", v, cv[0] + 16'h000a)
        `CHK("c2 held", o_latched, 3'h4)
        rd2(2'h2, v);
        `CHK("c2", v, w)
        wr(2'h3, 8'hc2);
        `CHK("rb", o_latched, 3'h0)
        `CHK("rb mode", o_mode_word[0], 6'h30)
        wr(2'h3, 8'h40);
        wr(2'h3, 8'h50);
        `CHK("new mode", o_mode_word[1], 6'h10)
        `CHK("cleared", o_latched, 3'h0)
        run(3'h2, 5);
        v = cv[1];
        wr(2'h3, 8'h40);
        run(3'h2, 5);
        rd(2'h1, b);
        `CHK("low only", b, v[7:0])
        `CHK("one read", o_latched, 3'h0)
        rd(2'h3, b);
        `CHK("ctrl rd", b, 8'h00)
        test_done();
    end
endmodule : tcr_readout_test
